/* rtl/pcc_counter_array.v */
// Counter array core with the cycle configuration register.
// Assumes a synchronous SFR bus on core_clk with one-cycle strobes.
`timescale 1ns/1ps
`include "pcc_defines.vh"
module pcc_counter_array (
    input wire core_clk, // System clock, 10 MHz
    input wire rst, // Asynchronous reset, active high
    input wire [3:0] sfr_page, // Current SFR page
    input wire [7:0] sfr_addr, // SFR address
    input wire [7:0] sfr_wdata, // Write data
    input wire sfr_wr, // Write strobe, one cycle
    input wire sfr_rd, // Read strobe, one cycle
    output reg [7:0] sfr_rdata, // Read data, valid cycle after sfr_rd
    output reg irq, // Counter array interrupt, from the cycle overflow flag only
    output reg [5:0] module_output_pin // PWM outputs
);
    ////////////////////////////////////////////////////////////////////////
    reg [15:0] counter_r;
    reg run_r;
    reg full_ovf_flag_r;
    reg reload_bank_select_r;
    reg cycle_overflow_irq_enable_r;
    reg cycle_overflow_flag_r;
    reg [1:0] cycle_length_select_r;
    reg [7:0] sfr_rdata_nxt;
    reg [10:0] cyc_top;
    wire [15:0] rd_cmp [0:5];
    wire [7:0] mode [0:5];
    wire [5:0] pin;
    wire pg0 = (sfr_page == `PCC_PAGE_MAIN);
    wire cfg_wr = sfr_wr && pg0 && (sfr_addr == `PCC_ADDR_CYCLE_CFG);
    wire ctl_wr = sfr_wr && pg0 && (sfr_addr == `PCC_ADDR_CTL);
    wire lo_wr = sfr_wr && pg0 && (sfr_addr == `PCC_ADDR_CTR_LO);
    wire hi_wr = sfr_wr && pg0 && (sfr_addr == `PCC_ADDR_CTR_HI);
    always @* begin
        case (cycle_length_select_r)
            2'b00: cyc_top = 11'h0_FF;
            2'b01: cyc_top = 11'h1_FF;
            2'b10: cyc_top = 11'h3_FF;
            default: cyc_top = 11'h7_FF;
        endcase
    end
    wire cycle_ovf = run_r && ((counter_r[10:0] & cyc_top) == cyc_top);
    wire full_ovf = run_r && (counter_r == `PCC_CTR_MAX);
    ////////////////////////////////////////////////////////////////////////
    // Main counter and control register
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            counter_r <= `PCC_RST_WORD;
            run_r <= 1'b0;
            full_ovf_flag_r <= 1'b0;
        end else begin
            if (lo_wr)
                counter_r[7:0] <= sfr_wdata;
            else if (hi_wr)
                counter_r[15:8] <= sfr_wdata;
            else if (run_r)
                counter_r <= counter_r + 16'h0001;
            if (ctl_wr)
                run_r <= sfr_wdata[`PCC_BIT_CTR_RUN];
            if (full_ovf)
                full_ovf_flag_r <= 1'b1;
            else if (ctl_wr)
                full_ovf_flag_r <= sfr_wdata[`PCC_BIT_CTR_OVF];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // cycle configuration, all zero at reset
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reload_bank_select_r <= 1'b0;
            cycle_overflow_irq_enable_r <= 1'b0;
            cycle_overflow_flag_r <= 1'b0;
            cycle_length_select_r <= 2'b00;
        end else begin
            if (cfg_wr) begin
                reload_bank_select_r <= sfr_wdata[`PCC_BIT_RELOAD_SEL];
                cycle_overflow_irq_enable_r <= sfr_wdata[`PCC_BIT_COV_IE];
                cycle_length_select_r <= sfr_wdata[`PCC_BIT_CYCLE_LENGTH_SELECT_HI:`PCC_BIT_CYCLE_LENGTH_SELECT_LO];
            end
            if (cycle_ovf)
                cycle_overflow_flag_r <= 1'b1;
            else if (cfg_wr)
                cycle_overflow_flag_r <= sfr_wdata[`PCC_BIT_COV_FLAG];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Six PWM modules
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_mod
            wire [7:0] cpm_addr = (g == 0) ? `PCC_ADDR_CPM0 : (g == 1) ? `PCC_ADDR_CPM1 :
                (g == 2) ? `PCC_ADDR_CPM2 : (g == 3) ? `PCC_ADDR_CPM3 :
                (g == 4) ? `PCC_ADDR_CPM4 : `PCC_ADDR_CPM5;
            localparam [7:0] CPL_OFF = 2 * g;
            wire [7:0] cpl_addr = `PCC_ADDR_CPL0 + CPL_OFF;
            pcc_pwm_channel u_ch (
                .core_clk(core_clk),
                .rst(rst),
                .wr_lo(sfr_wr && pg0 && sfr_addr == cpl_addr),
                .wr_hi(sfr_wr && pg0 && sfr_addr == cpl_addr + 8'h01),
                .reload_bank_select(reload_bank_select_r),
                .wdata(sfr_wdata),
                .mode_wdata(sfr_wdata),
                .mode_wr(sfr_wr && pg0 && sfr_addr == cpm_addr),
                .counter(counter_r),
                .cycle_length_select(cycle_length_select_r),
                .cycle_ovf(cycle_ovf),
                .full_ovf(full_ovf),
                .rd_compare(rd_cmp[g]),
                .mode(mode[g]),
                .module_output_pin(pin[g])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // Read mux; unused bits read zero
    integer i;
    always @* begin
        sfr_rdata_nxt = 8'h00;
        if (pg0) begin
            case (sfr_addr)
                `PCC_ADDR_CYCLE_CFG: sfr_rdata_nxt = {reload_bank_select_r,
                    cycle_overflow_irq_enable_r, cycle_overflow_flag_r, 3'b000,
                    cycle_length_select_r};
                `PCC_ADDR_CTL: sfr_rdata_nxt = {full_ovf_flag_r, run_r, 6'b00_0000};
                `PCC_ADDR_CTR_LO: sfr_rdata_nxt = counter_r[7:0];
                `PCC_ADDR_CTR_HI: sfr_rdata_nxt = counter_r[15:8];
                default: sfr_rdata_nxt = 8'h00;
            endcase
            for (i = 0; i < 6; i = i + 1) begin
                if (sfr_addr == `PCC_ADDR_CPL0 + 8'h02 * i[7:0])
                    sfr_rdata_nxt = rd_cmp[i][7:0];
                if (sfr_addr == `PCC_ADDR_CPL0 + 8'h02 * i[7:0] + 8'h01)
                    sfr_rdata_nxt = rd_cmp[i][15:8];
            end
            if (sfr_addr == `PCC_ADDR_CPM0) sfr_rdata_nxt = mode[0];
            if (sfr_addr == `PCC_ADDR_CPM1) sfr_rdata_nxt = mode[1];
            if (sfr_addr == `PCC_ADDR_CPM2) sfr_rdata_nxt = mode[2];
            if (sfr_addr == `PCC_ADDR_CPM3) sfr_rdata_nxt = mode[3];
            if (sfr_addr == `PCC_ADDR_CPM4) sfr_rdata_nxt = mode[4];
            if (sfr_addr == `PCC_ADDR_CPM5) sfr_rdata_nxt = mode[5];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= `PCC_RST_BYTE;
            irq <= 1'b0;
            module_output_pin <= 6'h00;
        end else begin
            if (sfr_rd)
                sfr_rdata <= sfr_rdata_nxt;
            irq <= cycle_overflow_irq_enable_r && cycle_overflow_flag_r;
            module_output_pin <= pin;
        end
    end
endmodule

/* rtl/pcc_defines.vh */
// Constants for the PWM cycle configuration block: addresses, fields, resets.
// Assumes an 8-bit special function register bus with a page number.
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// Register addresses and page
`define PCC_PAGE_MAIN 4'h0
`define PCC_ADDR_CYCLE_CFG 8'hDF
`define PCC_ADDR_CPM0 8'hDA
`define PCC_ADDR_CPM1 8'hDB
`define PCC_ADDR_CPM2 8'hDC
`define PCC_ADDR_CPM3 8'hDD
`define PCC_ADDR_CPM4 8'hDE
`define PCC_ADDR_CPM5 8'hCE
`define PCC_ADDR_CTR_LO 8'hF9
`define PCC_ADDR_CTR_HI 8'hFA
`define PCC_ADDR_CTL 8'hD8
`define PCC_ADDR_CPL0 8'hFB
`define PCC_ADDR_CPH0 8'hFC
// Cycle configuration fields
`define PCC_BIT_RELOAD_SEL 7
`define PCC_BIT_COV_IE 6
`define PCC_BIT_COV_FLAG 5
`define PCC_BIT_CYCLE_LENGTH_SELECT_HI 1
`define PCC_BIT_CYCLE_LENGTH_SELECT_LO 0
// Mode register fields
`define PCC_BIT_WIDE_PWM 7
`define PCC_BIT_ECOM 6
`define PCC_BIT_PULSE_EN 1
// Control register fields
`define PCC_BIT_CTR_OVF 7
`define PCC_BIT_CTR_RUN 6
// Reset values and counter maximum
`define PCC_RST_BYTE 8'h00
`define PCC_RST_WORD 16'h0000
`define PCC_CTR_MAX 16'hFFFF
`endif

/* rtl/pcc_pwm_channel.v */
// One PWM module: compare register, auto-reload register and output.
// Assumes counter and cycle overflow come from the same core_clk domain.
`timescale 1ns/1ps
`include "pcc_defines.vh"
module pcc_pwm_channel (
    input wire core_clk, // System clock
    input wire rst, // Asynchronous reset, active high
    input wire wr_lo, // Write low byte of compare
    input wire wr_hi, // Write high byte of compare
    input wire reload_bank_select, // Route access to reload bank
    input wire [7:0] wdata, // Write data
    input wire [7:0] mode_wdata, // Mode write data
    input wire mode_wr, // Mode register write
    input wire [15:0] counter, // Main counter value
    input wire [1:0] cycle_length_select, // Cycle length field
    input wire cycle_ovf, // Cycle overflow pulse
    input wire full_ovf, // Full counter overflow pulse
    output wire [15:0] rd_compare, // Visible compare or reload value
    output wire [7:0] mode, // Mode register value
    output reg module_output_pin // PWM output
);
    reg [15:0] cmp_r;
    reg [10:0] reload_r;
    reg [7:0] mode_r;
    reg [10:0] mask;
    wire wide = mode_r[`PCC_BIT_WIDE_PWM];
    wire pulse_en = mode_r[`PCC_BIT_PULSE_EN];
    assign rd_compare = reload_bank_select ? {5'h0_0, reload_r} : cmp_r;
    assign mode = mode_r;
    // Cycle length mask
    always @* begin
        case (cycle_length_select)
            2'b00: mask = 11'h0_FF;
            2'b01: mask = 11'h1_FF;
            2'b10: mask = 11'h3_FF;
            default: mask = 11'h7_FF;
        endcase
    end
    // Registers: routes writes, reload only at 9..11 bits
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_r <= `PCC_RST_WORD;
            reload_r <= 11'h0_00;
            mode_r <= `PCC_RST_BYTE;
        end else begin
            if (mode_wr)
                mode_r <= mode_wdata;
            if (wr_lo && reload_bank_select)
                reload_r[7:0] <= wdata;
            else if (wr_lo)
                cmp_r[7:0] <= wdata;
            if (wr_hi && reload_bank_select)
                reload_r[10:8] <= wdata[2:0];
            else if (wr_hi)
                cmp_r[15:8] <= wdata;
            if (cycle_ovf && pulse_en && !wide && cycle_length_select != 2'b00)
                cmp_r <= {5'h0_0, reload_r};
        end
    end
    // PWM output, width choice, shared length
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            module_output_pin <= 1'b0;
        else if (!pulse_en)
            module_output_pin <= 1'b0;
        else if (wide)
            module_output_pin <= (counter >= cmp_r);
        else
            module_output_pin <= ((counter[10:0] & mask) >= (cmp_r[10:0] & mask));
    end
endmodule

/* verification/pcc_chk.sv */
// Port checker for the counter array configuration register.
// Assumes it is bound to pcc_counter_array, one clock domain.
`timescale 1ns/1ps
module pcc_chk (
    input wire core_clk, // Clock
    input wire rst, // Reset
    input wire [3:0] sfr_page, // Page
    input wire [7:0] sfr_addr, // Address
    input wire [7:0] sfr_wdata, // Write data
    input wire sfr_wr, // Write strobe
    input wire sfr_rd, // Read strobe
    input wire [7:0] sfr_rdata, // Read data
    input wire irq, // Interrupt
    input wire [5:0] module_output_pin // PWM outputs
);
    // Decodes of register accesses
    wire cfg_sel = sfr_page == 4'h0 && sfr_addr == 8'hDF;
    wire cfg_wr = sfr_wr && cfg_sel;
    wire cfg_rd = sfr_rd && cfg_sel;
    wire far_rd = sfr_rd && sfr_page != 4'h0;
    reg ie_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of the interrupt enable bit
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            ie_r <= 1'b0;
        else if (cfg_wr)
            ie_r <= sfr_wdata[6];
    end
    ////////////////////////////////////////////////////////////////
    chk_rd_hold: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data moved without a read");
    chk_reset_quiet: assert property ($fell(rst) |-> !irq && sfr_rdata == 8'h00
        && module_output_pin == 6'h00) else $error("outputs not clear after reset");
    chk_other_page: assert property ($past(far_rd) |-> sfr_rdata == 8'h00)
        else $error("read on another page not zero");
    chk_unused_zero: assert property ($past(cfg_rd) |-> sfr_rdata[4:2] == 3'h0)
        else $error("unused bits not zero");
    chk_irq_gated: assert property (!$past(ie_r) |-> !irq)
        else $error("interrupt while disabled");
    chk_irq_soft_set: assert property (cfg_wr && sfr_wdata[6:5] == 2'h3 |-> ##2 irq)
        else $error("software set gave no interrupt");
    chk_flag_sticky: assert property (irq && !$past(cfg_wr) |=> irq)
        else $error("flag cleared without a write");
    chk_cfg_readback: assert property (cfg_wr ##2 cfg_rd |=>
        (sfr_rdata & 8'hC3) == ($past(sfr_wdata, 3) & 8'hC3))
        else $error("configuration read back wrong");
endmodule
bind pcc_counter_array pcc_chk chk_u (.core_clk(core_clk), .rst(rst),
    .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq(irq), .module_output_pin(module_output_pin));

/* verification/tb.sv */
// Self-checking bench for the counter array configuration register.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
module tb;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] sfr_page = 4'h0;
    reg [7:0] sfr_addr = 8'h00;
    reg [7:0] sfr_wdata = 8'h00;
    reg sfr_wr = 1'b0;
    reg sfr_rd = 1'b0;
    wire [7:0] sfr_rdata;
    wire irq;
    wire [5:0] pins;
    integer miscompares = 0;
    integer num_checks = 0;
    integer cycles = 0;
    integer n;
    pcc_counter_array dut_u (.core_clk(core_clk), .rst(rst), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .irq(irq), .module_output_pin(pins));
    // Clock and hang guard
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Compare and bus tasks
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected %s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d, input [3:0] pg = 4'h0);
        begin
            @(posedge core_clk);
            sfr_page <= pg;
            sfr_addr <= a;
            sfr_wdata <= d;
            sfr_wr <= 1'b1;
            @(posedge core_clk);
            sfr_wr <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp, input string what, input [3:0] pg = 4'h0);
        begin
            @(posedge core_clk);
            sfr_page <= pg;
            sfr_addr <= a;
            sfr_rd <= 1'b1;
            @(posedge core_clk);
            sfr_rd <= 1'b0;
            @(posedge core_clk);
            #1 chk(what, exp, (a == 8'hD8) ? (sfr_rdata & 8'h80) : sfr_rdata);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task t_fields;
        begin
            rdc(8'hDF, 8'h00, "cfg reset");
            wr(8'hDF, 8'hFF);
            rdc(8'hDF, 8'hE3, "cfg unused bits");
            chk("irq enabled", 8'h01, {7'h00, irq});
            wr(8'hDF, 8'h20);
            rdc(8'hDF, 8'h20, "flag kept");
            chk("irq masked", 8'h00, {7'h00, irq});
            wr(8'hDF, 8'h00);
            rdc(8'hDF, 8'h00, "flag cleared");
            wr(8'hDF, 8'hC3, 4'h1);
            rdc(8'hDF, 8'h00, "other page read", 4'h1);
            rdc(8'hDF, 8'h00, "other page write");
        end
    endtask
    task t_cycle(input [1:0] sel);
        integer len;
        begin
            len = 256 << sel;
            wr(8'hD8, 8'h00);
            wr(8'hF9, 8'h00);
            wr(8'hFA, 8'h00);
            wr(8'hDF, {6'h00, sel});
            wr(8'hD8, 8'h40);
            repeat (len - 16) @(posedge core_clk);
            rdc(8'hDF, {6'h00, sel}, "flag before wrap");
            repeat (16) @(posedge core_clk);
            rdc(8'hDF, {6'h08, sel}, "flag after wrap");
            chk("irq off", 8'h00, {7'h00, irq});
        end
    endtask
    task t_full;
        begin
            wr(8'hD8, 8'h00);
            wr(8'hF9, 8'hF0);
            wr(8'hFA, 8'hFF);
            wr(8'hD8, 8'h40);
            repeat (32) @(posedge core_clk);
            rdc(8'hD8, 8'h80, "full overflow");
        end
    endtask
    task t_reload;
        begin
            wr(8'hD8, 8'h00);
            wr(8'hDF, 8'h00);
            wr(8'hFB, 8'h34);
            wr(8'hFC, 8'h12);
            wr(8'hDF, 8'h80);
            wr(8'hFB, 8'h56);
            wr(8'hFC, 8'hFF);
            rdc(8'hFB, 8'h56, "reload low");
            rdc(8'hFC, 8'h07, "reload high");
            wr(8'hDF, 8'h01);
            wr(8'hD8, 8'h40);
            repeat (600) @(posedge core_clk);
            wr(8'hD8, 8'h00);
            rdc(8'hFB, 8'h34, "compare low");
            rdc(8'hFC, 8'h12, "compare high");
        end
    endtask
    task t_pwm;
        begin
            wr(8'hD8, 8'h00);
            wr(8'hDF, 8'h00);
            wr(8'hFB, 8'h80);
            wr(8'hFC, 8'h00);
            wr(8'hF9, 8'h00);
            wr(8'hFA, 8'h00);
            wr(8'hDA, 8'h02);
            repeat (2) @(posedge core_clk);
            #1 chk("pwm low", 8'h00, {2'b00, pins});
            wr(8'hF9, 8'h90);
            repeat (2) @(posedge core_clk);
            #1 chk("pwm high", 8'h01, {2'b00, pins});
            wr(8'hFC, 8'h01);
            repeat (2) @(posedge core_clk);
            #1 chk("pwm 8-bit length", 8'h01, {2'b00, pins});
            wr(8'hDA, 8'h82);
            repeat (2) @(posedge core_clk);
            #1 chk("pwm 16-bit", 8'h00, {2'b00, pins});
            wr(8'hDA, 8'h02);
            wr(8'hDF, 8'h81);
            wr(8'hFB, 8'h00);
            wr(8'hFC, 8'h00);
            wr(8'hDF, 8'h01);
            wr(8'hD8, 8'h40);
            repeat (600) @(posedge core_clk);
            wr(8'hD8, 8'h00);
            rdc(8'hFB, 8'h00, "reloaded low");
            rdc(8'hFC, 8'h00, "reloaded high");
            wr(8'hDA, 8'h00);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d, mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_fields;
        for (n = 0; n < 4; n = n + 1)
            t_cycle(n[1:0]);
        t_full;
        t_reload;
        t_pwm;
        final_report;
    end
endmodule
